// file: core/pefr_pkg.sv
/*
  Package of the peripheral event flag block: register offsets, field
  positions, reset values, modes and the event carriers.
  Assumes a 32-bit APB with byte addresses and one word per register.
*/
package pefr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] MASK_OFF = 8'h14;
  localparam logic [7:0] CTRL_OFF = 8'h18;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [2:0] CTRL_RST = 3'h1;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int BIT_PSP = 7;
  localparam int BIT_ADC = 6;
  localparam int BIT_RX = 5;
  localparam int BIT_TX = 4;
  localparam int BIT_SSP = 3;
  localparam int BIT_CCP = 2;
  localparam int BIT_T2 = 1;
  localparam int BIT_T1 = 0;
  // Software writable flag bits
  localparam logic [7:0] FLAGS_WMASK = 8'hcf;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_PSP_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 2;

  // ----------------------------------------------------------------
  // Modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PEFR_CAPTURE,
    PEFR_COMPARE,
    PEFR_PWM,
    PEFR_OFF
  } pefr_ccp_e;

  typedef struct packed {
    logic psp_access;
    logic conv_done;
    logic sync_done;
    logic capture;
    logic compare_match;
    logic t2_match;
    logic t1_overflow;
  } pefr_evt_s;

  typedef struct packed {
    logic rx_full;
    logic tx_empty;
  } pefr_lvl_s;
endpackage : pefr_pkg

// file: core/pefr_top.sv
/*
  Peripheral event flag register with APB access, a read-to-clear
  event status, a mask and one level interrupt.
  Assumes event pulses and serial buffer levels synchronous to clk.
*/
// Local design decision: the APB register port.
// Behaviour
// - Flags set on their event, bits 5 and 4 follow the buffer levels; bit 7 only while control bit 0 is set, bit 2 per the CCP mode.
// - Eight-bit flag register at 0Ch, all bits zero after reset.
// - Bit 7 sets on parallel port access, held until software clears.
// - Bit 6 sets on conversion done, held until software writes zero.
// - Bit 3 sets on sync serial transfer done, cleared only by software.
// - Capture mode: bit 2 sets on capture, held until cleared.
// - Compare mode: bit 2 sets on compare match; unused in PWM mode.
// - Bit 1 sets on timer two period match, held until cleared.
`timescale 1ns/100ps
`default_nettype none

module pefr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral events and levels
  input wire pefr_pkg::pefr_evt_s evt,
  input wire pefr_pkg::pefr_lvl_s lvl,
  // Flags and interrupt
  output logic [7:0] flags,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] mask;
  logic [2:0] ctrl;
  logic [7:0] evt_vec;
  logic [7:0] next_flags;
  logic [7:0] next_status;
  logic [7:0] flag_rise;
  logic [7:0] flags_wr;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic access;
  logic setup_hit;
  logic wr_en;
  logic rd_en;
  logic hit_flags;
  logic hit_status;
  logic hit_mask;
  logic hit_ctrl;
  logic mapped;
  logic psp_present;
  pefr_pkg::pefr_ccp_e ccp_mode;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign setup_hit = psel & penable & ~pready;
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite & pstrb[0];
  assign rd_en = access & ~pwrite;
  assign hit_flags = (paddr == pefr_pkg::FLAGS_OFF);
  assign hit_status = (paddr == pefr_pkg::STATUS_OFF);
  assign hit_mask = (paddr == pefr_pkg::MASK_OFF);
  assign hit_ctrl = (paddr == pefr_pkg::CTRL_OFF);
  assign mapped = hit_flags | hit_status | hit_mask | hit_ctrl;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign psp_present = ctrl[pefr_pkg::CTRL_PSP_BIT];
  assign ccp_mode = pefr_pkg::pefr_ccp_e'(
    ctrl[pefr_pkg::CTRL_MODE_MSB:pefr_pkg::CTRL_MODE_LSB]);

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  always_comb begin
    evt_vec = 8'h00;
    evt_vec[pefr_pkg::BIT_PSP] = evt.psp_access & psp_present;
    evt_vec[pefr_pkg::BIT_ADC] = evt.conv_done;
    evt_vec[pefr_pkg::BIT_SSP] = evt.sync_done;
    case (ccp_mode)
      pefr_pkg::PEFR_CAPTURE: begin
        evt_vec[pefr_pkg::BIT_CCP] = evt.capture;
      end
      pefr_pkg::PEFR_COMPARE: begin
        evt_vec[pefr_pkg::BIT_CCP] = evt.compare_match;
      end
      pefr_pkg::PEFR_PWM: begin
        evt_vec[pefr_pkg::BIT_CCP] = 1'b0;
      end
      default: begin
        evt_vec[pefr_pkg::BIT_CCP] = 1'b0;
      end
    endcase
    evt_vec[pefr_pkg::BIT_T2] = evt.t2_match;
    evt_vec[pefr_pkg::BIT_T1] = evt.t1_overflow;
  end

  // ----------------------------------------------------------------
  // Flag next state, one slice per bit
  // ----------------------------------------------------------------
  assign flags_wr = pwdata[7:0];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      if (gi == pefr_pkg::BIT_RX) begin : g_rx
        // Follows the receive buffer level
        assign next_flags[gi] = lvl.rx_full;
      end else if (gi == pefr_pkg::BIT_TX) begin : g_tx
        // Follows the transmit buffer level
        assign next_flags[gi] = lvl.tx_empty;
      end else begin : g_rw
        // Event set wins over a software write
        assign next_flags[gi] = evt_vec[gi]
          | ((wr_en & hit_flags) ? flags_wr[gi] : flags[gi]);
      end
      assign flag_rise[gi] = next_flags[gi] & ~flags[gi];
      // Sticky status, set wins over read clear
      assign next_status[gi] = flag_rise[gi]
        | (status[gi] & ~(rd_en & hit_status));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      flags <= pefr_pkg::FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= pefr_pkg::STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask <= pefr_pkg::MASK_RST;
    end else if (wr_en & hit_mask) begin
      mask <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= pefr_pkg::CTRL_RST;
    end else if (wr_en & hit_ctrl) begin
      ctrl <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data and error
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (hit_flags) begin
      next_prdata[7:0] = flags & pefr_pkg::FLAGS_WMASK;
      next_prdata[pefr_pkg::BIT_RX] = flags[pefr_pkg::BIT_RX];
      next_prdata[pefr_pkg::BIT_TX] = flags[pefr_pkg::BIT_TX];
    end else if (hit_status) begin
      next_prdata[7:0] = status;
    end else if (hit_mask) begin
      next_prdata[7:0] = mask;
    end else if (hit_ctrl) begin
      next_prdata[2:0] = ctrl;
    end else begin
      next_slverr = 1'b1;
    end
    if (~mapped) begin
      next_prdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state in the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pslverr <= 1'b0;
    end else if (setup_hit) begin
      pslverr <= next_slverr;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_hit & ~pwrite) begin
      prdata <= next_prdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule : pefr_top

`default_nettype wire

// file: sim/pefr_top_monitor.sv
/*
  Port checker of the peripheral event flag block.
  Assumes one clock, synchronous reset srst; bound to pefr_top below.
*/
`timescale 1ns/100ps
`default_nettype none

module pefr_top_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events, flags, interrupt
  input wire pefr_pkg::pefr_evt_s evt,
  input wire pefr_pkg::pefr_lvl_s lvl,
  input wire logic [7:0] flags,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic done;
  logic wr_flags;
  assign done = psel && penable && pready;
  assign wr_flags = done && pwrite && pstrb[0] && paddr == pefr_pkg::FLAGS_OFF;

  a_conv_sets: assert property (evt.conv_done |=> flags[6])
    else $error("conversion flag not set");
  a_ovf_sets: assert property (evt.t1_overflow |=> flags[0])
    else $error("overflow flag not set");
  a_match_sets: assert property (evt.t2_match |=> flags[1])
    else $error("period match flag not set");
  a_sync_sets: assert property (evt.sync_done |=> flags[3])
    else $error("sync serial flag not set");
  a_flags_sticky: assert property (!wr_flags |=>
    (flags & $past(flags) & 8'hcf) == ($past(flags) & 8'hcf))
    else $error("flag cleared without software write");
  a_level_bits: assert property (!$past(srst) |-> flags[5:4] == $past(lvl))
    else $error("serial level bits wrong");
  a_read_flags: assert property (done && !pwrite && paddr == 8'h0c |->
    prdata[7:0] == $past(flags) && !pslverr)
    else $error("flag register read wrong");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule : pefr_top_monitor

bind pefr_top pefr_top_monitor u_mon (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .evt(evt), .lvl(lvl), .flags(flags), .irq(irq));

`default_nettype wire

// file: sim/tb_pefr_top.sv
/*
  Testbench of the peripheral event flag block over APB.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_pefr_top;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, flags;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  pefr_pkg::pefr_evt_s evt;
  pefr_pkg::pefr_lvl_s lvl;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rdv;
  logic erv;
  logic [7:0] ebit [7] = '{8'h01, 8'h02, 8'h00, 8'h04, 8'h08, 8'h40, 8'h80};

  pefr_top dut (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .lvl(lvl), .flags(flags), .irq(irq));

  always #25 clk = ~clk;

  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task pulse(input int i);
    @(posedge clk);
    evt <= pefr_pkg::pefr_evt_s'(7'h1 << i);
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; pstrb = 4'hf; evt = '0; lvl = '0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(8'h0c, 32'h0, 1'b0);
    rd(pefr_pkg::STATUS_OFF, 32'h0, 1'b0);
    rd(pefr_pkg::MASK_OFF, 32'h0, 1'b0);
    rd(pefr_pkg::CTRL_OFF, 32'h1, 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    apb(1'b1, 8'h1c, 32'h0, rdv, erv);
    chk({31'h0, erv}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 7; i++) if (i != 2) begin
      pulse(i);
      chk(32'(flags), 32'(ebit[i]));
      wr(8'h0c, 32'h0);
      @(posedge clk);
      chk(32'(flags), 32'h0);
    end
    wr(pefr_pkg::CTRL_OFF, 32'h3);
    pulse(2);
    chk(32'(flags), 32'h04);
    wr(8'h0c, 32'h0);
    wr(pefr_pkg::CTRL_OFF, 32'h5);
    pulse(2);
    chk(32'(flags), 32'h0);
    wr(pefr_pkg::CTRL_OFF, 32'h7);
    pulse(3);
    chk(32'(flags), 32'h0);
    wr(pefr_pkg::CTRL_OFF, 32'h0);
    pulse(6);
    chk(32'(flags), 32'h0);
    $display("test events done");
    lvl <= 2'b10;
    wr(8'h0c, 32'h7f);
    rd(8'h0c, 32'h6f, 1'b0);
    pstrb <= 4'h0;
    wr(8'h0c, 32'h0);
    pstrb <= 4'hf;
    rd(8'h0c, 32'h6f, 1'b0);
    lvl <= 2'b00;
    wr(8'h0c, 32'h0);
    $display("test access done");
    wr(pefr_pkg::STATUS_OFF, 32'h0);
    rd(pefr_pkg::STATUS_OFF, 32'hef, 1'b0);
    rd(pefr_pkg::STATUS_OFF, 32'h0, 1'b0);
    wr(pefr_pkg::MASK_OFF, 32'h40);
    pulse(5);
    chk({31'h0, irq}, 32'h1);
    pulse(0);
    rd(pefr_pkg::STATUS_OFF, 32'h41, 1'b0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    pulse(0);
    chk({31'h0, irq}, 32'h0);
    chk(32'(flags), 32'h41);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule : tb_pefr_top

`default_nettype wire
